/* core/rtcac_pkg.sv */
package rtcac_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int NUM_TIME = 7;
	localparam int NUM_ALM = 4;
	localparam logic [6:0] A_SEC = 7'h00;
	localparam logic [6:0] A_HOUR = 7'h02;
	localparam logic [6:0] A_ALM_FIRST = 7'h07;
	localparam logic [6:0] A_ALM_LAST = 7'h0a;
	localparam logic [6:0] A_CONTROL = 7'h0b;
	localparam logic [6:0] A_STATUS = 7'h0c;
	localparam logic [6:0] A_WDOG = 7'h0d;
	localparam logic [6:0] A_ADC = 7'h0e;
	localparam logic [6:0] A_LAST = 7'h0e;
	localparam int CMD_WRITE_BIT = 7;
	localparam int CTL_OSC_STOP = 7;
	localparam int CTL_WLOCK = 6;
	localparam int CTL_SEL_HI = 5;
	localparam int CTL_SEL_LO = 4;
	localparam int CTL_AIE = 0;
	localparam int ST_CONV = 7;
	localparam int ST_BAT = 6;
	localparam int ST_FLAG = 0;
	localparam int HR_MODE12 = 6;
	localparam int HR_PM = 5;
	localparam int ALM_MASK_BIT = 7;
	localparam logic [7:0] MASK_TIME [NUM_TIME] = '{8'h7f, 8'h7f, 8'h7f, 8'h07, 8'h3f, 8'h1f, 8'hff};
	localparam logic [7:0] MASK_ALM [NUM_ALM] = '{8'hff, 8'hff, 8'hff, 8'h87};
	localparam logic [7:0] MASK_CONTROL = 8'hf1;
	localparam logic [7:0] MASK_WDOG = 8'h03;
	localparam logic [7:0] RST_TIME [NUM_TIME] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
	localparam logic [7:0] RST_ALM = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h80;
	localparam logic [7:0] RST_WDOG = 8'h03;
	localparam logic [7:0] BCD_59 = 8'h59;
	localparam logic [5:0] BCD_23 = 6'h23;
	localparam logic [4:0] BCD_12 = 5'h12;
	localparam logic [4:0] BCD_11 = 5'h11;
	localparam logic [4:0] BCD_01 = 5'h01;
	localparam int XTAL_DIV_DEFAULT = 32768;
	typedef enum logic [1:0] {
		SP_IDLE = 2'b00,
		SP_CMD = 2'b01,
		SP_WRITE = 2'b10,
		SP_READ = 2'b11
	} rtcac_sp_e;
endpackage

/* core/rtcac_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rtcac_reg_if;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic busy;
	logic [7:0] rdata;
	modport port (output addr, output wdata, output wr, output rd, output busy, input rdata);
	modport regs (input addr, input wdata, input wr, input rd, input busy, output rdata);
endinterface
`default_nettype wire

/* core/rtcac_serial.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcac_serial
	import rtcac_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_cs,
	input wire logic i_sclk,
	input wire logic i_io,
	output logic o_io,
	output logic o_io_oe,
	rtcac_reg_if.port bus
);
	logic [1:0] cs_sync;
	logic [2:0] sclk_sync;
	logic [1:0] io_sync;
	logic sclk_rise;
	logic sclk_fall;
	rtcac_sp_e state;
	logic [2:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] next_byte;
	logic [6:0] next_addr;

	// stage 0 feeds stage 1 only; edges are taken between stages 1 and 2
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			cs_sync <= 2'h0;
			sclk_sync <= 3'h0;
			io_sync <= 2'h0;
		end
		else if (i_ce)
		begin
			cs_sync <= {cs_sync[0], i_cs};
			sclk_sync <= {sclk_sync[1:0], i_sclk};
			io_sync <= {io_sync[0], i_io};
		end
	end

	assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
	assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
	assign next_byte = {io_sync[1], shift[7:1]};
	assign next_addr = (bus.addr == A_LAST) ? 7'h00 : 7'(bus.addr + 7'h01);

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			state <= SP_IDLE;
			bit_cnt <= 3'h0;
			shift <= 8'h00;
			bus.addr <= 7'h00;
			bus.wdata <= 8'h00;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			bus.busy <= 1'b0;
			o_io <= 1'b0;
			o_io_oe <= 1'b0;
		end
		else if (i_ce)
		begin
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			bus.busy <= cs_sync[1];
			if (!cs_sync[1])
			begin
				state <= SP_IDLE;
				bit_cnt <= 3'h0;
				o_io_oe <= 1'b0;
			end
			else
			begin
				case (state)
					SP_IDLE:
					begin
						state <= SP_CMD;
						bit_cnt <= 3'h0;
					end
					SP_CMD:
					begin
						if (sclk_rise)
						begin
							shift <= next_byte;
							bit_cnt <= 3'(bit_cnt + 3'h1);
							if (bit_cnt == 3'h7)
							begin
								bus.addr <= next_byte[6:0];
								state <= next_byte[CMD_WRITE_BIT] ? SP_WRITE : SP_READ;
							end
						end
					end
					SP_WRITE:
					begin
						if (sclk_rise)
						begin
							shift <= next_byte;
							bit_cnt <= 3'(bit_cnt + 3'h1);
							if (bit_cnt == 3'h7)
							begin
								bus.wdata <= next_byte;
								bus.wr <= 1'b1;
							end
						end
						if (bus.wr)
						begin
							bus.addr <= next_addr;
						end
					end
					SP_READ:
					begin
						if (sclk_fall)
						begin
							bit_cnt <= 3'(bit_cnt + 3'h1);
							o_io_oe <= 1'b1;
							if (bit_cnt == 3'h0)
							begin
								o_io <= bus.rdata[0];
								shift <= {1'b0, bus.rdata[7:1]};
								bus.rd <= 1'b1;
							end
							else
							begin
								o_io <= shift[0];
								shift <= {1'b0, shift[7:1]};
							end
							if (bit_cnt == 3'h7)
							begin
								bus.addr <= next_addr;
							end
						end
					end
					default:
					begin
						state <= SP_IDLE;
					end
				endcase
			end
		end
	end
endmodule // rtcac_serial
`default_nettype wire

/* core/rtcac_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcac_top
	import rtcac_pkg::*;
#(
	parameter int XTAL_DIV = XTAL_DIV_DEFAULT
)
(
	input wire logic I_REF_CLK,
	input wire logic I_RST_B,
	input wire logic I_CE,
	input wire logic I_CS,
	input wire logic I_SCLK,
	input wire logic I_IO_IN,
	output logic O_IO_OUT,
	output logic O_IO_OE,
	input wire logic I_XTAL,
	input wire logic I_MAIN_POWER,
	input wire logic I_VBAT_ABOVE_HI,
	input wire logic I_VBAT_BELOW_LO,
	input wire logic I_CONV_SOON,
	input wire logic [7:0] I_ADC_DATA,
	output logic O_INT,
	output logic O_OSC_EN,
	output logic [2:0] O_AIN_SEL,
	output logic [1:0] O_WDOG_PERIOD
);
	localparam int PRE_W = $clog2(XTAL_DIV);

	generate
		if (XTAL_DIV < 2)
		begin : g_bad_div
			$error("XTAL_DIV must be at least 2");
		end
	endgenerate

	rtcac_reg_if bus ();

	logic [1:0] xtal_sync;
	logic xtal_prev;
	logic [1:0] pwr_sync;
	logic [1:0] hi_sync;
	logic [1:0] lo_sync;
	logic [1:0] conv_sync;
	logic [7:0] adc_sync0;
	logic [7:0] adc_sync1;
	logic [7:0] adc_prev;
	logic [PRE_W-1:0] prescale;
	logic sec_tick;
	logic tick_done;
	logic [7:0] tm [NUM_TIME];
	logic [7:0] alm [NUM_ALM];
	logic [7:0] control;
	logic [7:0] wdog;
	logic [7:0] adc_reg;
	logic conv_pending;
	logic battery_low_flag;
	logic alarm_flag;
	logic run;
	logic wr_ok;
	logic alm_access;
	logic alarm_match;
	logic [NUM_ALM-1:0] field_ok;
	logic [6:0] next_hour;
	logic day_roll;
	logic [7:0] month_end;
	logic leap;

	rtcac_serial u_serial (
		.i_clk(I_REF_CLK),
		.i_rst_b(I_RST_B),
		.i_ce(I_CE),
		.i_cs(I_CS),
		.i_sclk(I_SCLK),
		.i_io(I_IO_IN),
		.o_io(O_IO_OUT),
		.o_io_oe(O_IO_OE),
		.bus(bus.port)
	);

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
		begin
			bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
		end
		else
		begin
			bcd_inc = 8'(v + 8'h01);
		end
	endfunction

	// pin inputs pass two stages before use
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_B)
		begin
			xtal_sync <= 2'h0;
			xtal_prev <= 1'b0;
			pwr_sync <= 2'h0;
			hi_sync <= 2'h0;
			lo_sync <= 2'h0;
			conv_sync <= 2'h0;
			adc_sync0 <= 8'h00;
			adc_sync1 <= 8'h00;
			adc_prev <= 8'h00;
		end
		else if (I_CE)
		begin
			xtal_sync <= {xtal_sync[0], I_XTAL};
			xtal_prev <= xtal_sync[1];
			pwr_sync <= {pwr_sync[0], I_MAIN_POWER};
			hi_sync <= {hi_sync[0], I_VBAT_ABOVE_HI};
			lo_sync <= {lo_sync[0], I_VBAT_BELOW_LO};
			conv_sync <= {conv_sync[0], I_CONV_SOON};
			adc_sync0 <= I_ADC_DATA;
			adc_sync1 <= adc_sync0;
			adc_prev <= adc_sync1;
		end
	end

	assign run = ~control[CTL_OSC_STOP];

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_B)
		begin
			prescale <= '0;
			sec_tick <= 1'b0;
			tick_done <= 1'b0;
		end
		else if (I_CE)
		begin
			sec_tick <= 1'b0;
			tick_done <= sec_tick;
			if (!run)
			begin
				prescale <= '0;
			end
			else if (xtal_sync[1] & ~xtal_prev)
			begin
				if (prescale == PRE_W'(XTAL_DIV - 1))
				begin
					prescale <= '0;
					sec_tick <= 1'b1;
				end
				else
				begin
					prescale <= PRE_W'(prescale + 1'b1);
				end
			end
		end
	end

	assign wr_ok = bus.wr & ~control[CTL_WLOCK];

	always_comb
	begin
		next_hour = 7'(bcd_inc({1'b0, tm[2][6:0]}));
		day_roll = 1'b0;
		if (tm[2][HR_MODE12])
		begin
			if (tm[2][4:0] == BCD_12)
			begin
				next_hour = {tm[2][6:5], BCD_01};
			end
			else if (tm[2][4:0] == BCD_11)
			begin
				next_hour = {tm[2][6], ~tm[2][HR_PM], BCD_12};
				day_roll = tm[2][HR_PM];
			end
			else
			begin
				next_hour = {tm[2][6:5], 5'(bcd_inc({3'h0, tm[2][4:0]}))};
			end
		end
		else if (tm[2][5:0] == BCD_23)
		begin
			next_hour = 7'h00;
			day_roll = 1'b1;
		end
	end

	// leap test on bcd year, good through 2099
	always_comb
	begin
		leap = tm[6][4] ? (tm[6][3:0] == 4'h2 || tm[6][3:0] == 4'h6)
			: (tm[6][3:0] == 4'h0 || tm[6][3:0] == 4'h4 || tm[6][3:0] == 4'h8);
		case (tm[5][4:0])
			5'h02: month_end = leap ? 8'h29 : 8'h28;
			5'h04, 5'h06, 5'h09, 5'h11: month_end = 8'h30;
			default: month_end = 8'h31;
		endcase
	end

	// a host write wins over the tick for that second
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_B)
		begin
			for (int i = 0; i < NUM_TIME; i++)
			begin
				tm[i] <= RST_TIME[i];
			end
		end
		else if (I_CE)
		begin
			// only implemented time slots take data
			if (wr_ok && bus.addr < A_ALM_FIRST)
			begin
				tm[bus.addr[2:0]] <= bus.wdata & MASK_TIME[bus.addr[2:0]];
			end
			else if (sec_tick)
			begin
				tm[0] <= bcd_inc(tm[0]);
				if (tm[0] == BCD_59)
				begin
					tm[0] <= 8'h00;
					tm[1] <= bcd_inc(tm[1]);
					if (tm[1] == BCD_59)
					begin
						tm[1] <= 8'h00;
						tm[2] <= {1'b0, next_hour};
						if (day_roll)
						begin
							tm[3] <= (tm[3] == 8'h07) ? 8'h01 : 8'(tm[3] + 8'h01);
							tm[4] <= bcd_inc(tm[4]);
							if (tm[4] == month_end)
							begin
								tm[4] <= 8'h01;
								tm[5] <= bcd_inc(tm[5]);
								if (tm[5] == 8'h12)
								begin
									tm[5] <= 8'h01;
									tm[6] <= (tm[6] == 8'h99) ? 8'h00 : bcd_inc(tm[6]);
								end
							end
						end
					end
				end
			end
		end
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_B)
		begin
			for (int i = 0; i < NUM_ALM; i++)
			begin
				alm[i] <= RST_ALM;
			end
		end
		else if (I_CE)
		begin
			if (wr_ok && bus.addr >= A_ALM_FIRST && bus.addr <= A_ALM_LAST)
			begin
				alm[2'(bus.addr - A_ALM_FIRST)] <= bus.wdata & MASK_ALM[2'(bus.addr - A_ALM_FIRST)];
			end
		end
	end

	// each field passes when masked or equal
	generate
		for (genvar f = 0; f < NUM_ALM; f++)
		begin : g_field
			assign field_ok[f] = alm[f][ALM_MASK_BIT] || (alm[f][6:0] == tm[f][6:0]);
		end
	endgenerate

	assign alarm_match = &field_ok;
	assign alm_access = (bus.wr | bus.rd) && bus.addr >= A_ALM_FIRST && bus.addr <= A_ALM_LAST;

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_B)
		begin
			alarm_flag <= 1'b0;
		end
		else if (I_CE)
		begin
			// match sets flag, set beats clear
			if (tick_done && alarm_match)
			begin
				alarm_flag <= 1'b1;
			end
			else if (alm_access)
			begin
				alarm_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_B)
		begin
			control <= RST_CONTROL;
			wdog <= RST_WDOG;
		end
		else if (I_CE && bus.wr)
		begin
			if (bus.addr == A_CONTROL)
			begin
				if (control[CTL_WLOCK])
				begin
					control[CTL_WLOCK] <= bus.wdata[CTL_WLOCK];
				end
				else
				begin
					control <= bus.wdata & MASK_CONTROL;
				end
			end
			else if (wr_ok && bus.addr == A_WDOG)
			begin
				wdog <= bus.wdata & MASK_WDOG;
			end
		end
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_B)
		begin
			battery_low_flag <= 1'b0;
			conv_pending <= 1'b0;
			adc_reg <= 8'h00;
		end
		else if (I_CE)
		begin
			if (hi_sync[1])
			begin
				battery_low_flag <= 1'b0;
			end
			else if (lo_sync[1])
			begin
				battery_low_flag <= 1'b1;
			end
			conv_pending <= conv_sync[1];
			// held while a transfer is open so a read stays stable;
			// a word is taken only when two samples agree, so no torn bits
			if (!bus.busy && adc_sync1 == adc_prev)
			begin
				adc_reg <= adc_sync1;
			end
		end
	end

	always_comb
	begin
		bus.rdata = 8'h00;
		if (bus.addr < A_ALM_FIRST)
		begin
			bus.rdata = tm[bus.addr[2:0]];
		end
		else if (bus.addr <= A_ALM_LAST)
		begin
			bus.rdata = alm[2'(bus.addr - A_ALM_FIRST)];
		end
		else if (bus.addr == A_CONTROL)
		begin
			bus.rdata = control;
		end
		else if (bus.addr == A_STATUS)
		begin
			bus.rdata[ST_CONV] = conv_pending;
			bus.rdata[ST_BAT] = battery_low_flag;
			bus.rdata[ST_FLAG] = alarm_flag;
		end
		else if (bus.addr == A_WDOG)
		begin
			bus.rdata = wdog;
		end
		else if (bus.addr == A_ADC)
		begin
			bus.rdata = adc_reg;
		end
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_B)
		begin
			O_INT <= 1'b0;
			O_OSC_EN <= 1'b0;
			O_AIN_SEL <= 3'h0;
			O_WDOG_PERIOD <= 2'h0;
		end
		else if (I_CE)
		begin
			O_INT <= alarm_flag & control[CTL_AIE];
			O_OSC_EN <= run | pwr_sync[1];
			// one-hot input choice, zero is off
			case ({control[CTL_SEL_HI], control[CTL_SEL_LO]})
				2'b01: O_AIN_SEL <= 3'b001;
				2'b10: O_AIN_SEL <= 3'b010;
				2'b11: O_AIN_SEL <= 3'b100;
				default: O_AIN_SEL <= 3'b000;
			endcase
			O_WDOG_PERIOD <= wdog[1:0];
		end
	end
endmodule // rtcac_top
`default_nettype wire

/* verif/rtcac_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcac_chk_sva (
	input wire logic I_REF_CLK,
	input wire logic I_RST_B,
	input wire logic I_CS,
	input wire logic I_MAIN_POWER,
	input wire logic O_IO_OE,
	input wire logic O_INT,
	input wire logic O_OSC_EN,
	input wire logic [2:0] O_AIN_SEL,
	input wire logic [1:0] O_WDOG_PERIOD
);
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RST_B);
	// cs is synced, so release lags a few clocks
	property p_oe_idle;
		(!I_CS) [*6] |-> !O_IO_OE;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("io driven while idle");
	property p_oe_cmd;
		$rose(I_CS) |-> (!O_IO_OE) [*8];
	endproperty
	a_oe_cmd: assert property (p_oe_cmd) else $error("io driven in command");
	property p_sel_hot;
		$onehot0(O_AIN_SEL);
	endproperty
	a_sel_hot: assert property (p_sel_hot) else $error("select not one-hot");
	property p_sel_stable;
		(!I_CS) [*6] |=> $stable(O_AIN_SEL);
	endproperty
	a_sel_stable: assert property (p_sel_stable) else $error("select moved");
	property p_wdog_rst;
		$rose(I_RST_B) |-> ##[1:3] O_WDOG_PERIOD == 2'h3;
	endproperty
	a_wdog_rst: assert property (p_wdog_rst) else $error("watchdog default");
	property p_int_rst;
		$rose(I_RST_B) |-> !O_INT;
	endproperty
	a_int_rst: assert property (p_int_rst) else $error("interrupt at reset");
	// power pin is synced, so the enable follows three clocks late
	property p_osc_main;
		I_MAIN_POWER [*6] |-> O_OSC_EN;
	endproperty
	a_osc_main: assert property (p_osc_main) else $error("oscillator off");
	property p_int_hold;
		(!I_CS) [*6] ##0 O_INT |=> O_INT;
	endproperty
	a_int_hold: assert property (p_int_hold) else $error("interrupt dropped");
	cover property ($rose(O_INT));
	cover property ($rose(O_IO_OE));
	cover property (O_AIN_SEL == 3'h4);
	cover property ($fell(O_OSC_EN));
endmodule // rtcac_chk_sva
bind rtcac_top rtcac_chk_sva u_chk (
	.I_REF_CLK(I_REF_CLK),
	.I_RST_B(I_RST_B),
	.I_CS(I_CS),
	.I_MAIN_POWER(I_MAIN_POWER),
	.O_IO_OE(O_IO_OE),
	.O_INT(O_INT),
	.O_OSC_EN(O_OSC_EN),
	.O_AIN_SEL(O_AIN_SEL),
	.O_WDOG_PERIOD(O_WDOG_PERIOD)
);
`default_nettype wire

/* verif/rtcac_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcac_host (
	input wire logic i_clk,
	input wire logic i_io,
	output logic o_cs,
	output logic o_sclk,
	output logic o_io,
	output logic o_oe
);
	logic [7:0] dat [16];
	initial
	begin
		o_cs = 0;
		o_sclk = 0;
		o_io = 0;
		o_oe = 0;
	end
	// lsb first, 200 ns link period
	task automatic bit_cyc(input logic d, input logic drv, output logic q);
		o_io = d;
		o_oe = drv;
		repeat (4) @(negedge i_clk);
		q = i_io;
		o_sclk = 1;
		repeat (4) @(negedge i_clk);
		o_sclk = 0;
	endtask
	task automatic frame(input logic [7:0] cmd, input int n);
		logic q;
		o_cs = 1;
		repeat (8) @(negedge i_clk);
		for (int i = 0; i < 8; i++)
			bit_cyc(cmd[i], 1'b1, q);
		for (int k = 0; k < n; k++)
			for (int i = 0; i < 8; i++)
			begin
				bit_cyc(dat[k][i], cmd[7], q);
				dat[k][i] = q;
			end
		repeat (4) @(negedge i_clk);
		o_cs = 0;
		o_oe = 0;
		repeat (12) @(negedge i_clk);
	endtask
endmodule // rtcac_host
`default_nettype wire

/* verif/rtcac_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcac_top_bench;
	import rtcac_pkg::*;
	logic clk = 0;
	logic rst_b = 0;
	logic xtal = 0;
	logic hi = 1;
	logic pwr = 1;
	logic lo = 0;
	logic conv = 0;
	logic [7:0] adc = 8'h00;
	logic cs, sclk, h_io, h_oe, io_out, io_oe, irq, osc;
	wire io_in;
	logic [2:0] sel;
	logic [1:0] wdp;
	logic [7:0] m [15];
	logic flag = 0;
	logic bat = 0;
	logic [31:0] seed = 32'ha6df;
	int fail_count = 0;
	int samples_checked = 0;
	// time, alarms, control, time after one tick, alarm flag
	logic [159:0] row [8] = '{
		160'h5959230728020180808080010000000101030101,
		160'h5959710329020400005204010000520401030401,
		160'h5959510331129900007205010000720331129900,
		160'h5959510331129900007285010000720331129901,
		160'h5959190331129980808080000000200331129901,
		160'h1059190331129980808080811059190331129900,
		160'h3014080215062131808080013114080215062101,
		160'h5914080215062100158080010015080215062101};
	always #12.5 clk = ~clk;
	// no pull on the line: released wire shows inverted data
	assign io_in = h_oe ? h_io : (io_oe ? io_out : ~h_io);
	rtcac_top #(.XTAL_DIV(4)) u_rtcac_top (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_CE(1'b1),
		.I_CS(cs), .I_SCLK(sclk), .I_IO_IN(io_in), .O_IO_OUT(io_out), .O_IO_OE(io_oe),
		.I_XTAL(xtal), .I_MAIN_POWER(pwr), .I_VBAT_ABOVE_HI(hi), .I_VBAT_BELOW_LO(lo),
		.I_CONV_SOON(conv), .I_ADC_DATA(adc), .O_INT(irq), .O_OSC_EN(osc),
		.O_AIN_SEL(sel), .O_WDOG_PERIOD(wdp));
	rtcac_host u_host (.i_clk(clk), .i_io(io_in), .o_cs(cs), .o_sclk(sclk), .o_io(h_io),
		.o_oe(h_oe));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic int nx(int a);
		return (a == 14 || a == 127) ? 0 : a + 1;
	endfunction
	function automatic logic [7:0] exp_rd(int a);
		if (a == 12)
			return {conv, bat, 5'h00, flag};
		if (a == 14)
			return adc;
		return (a > 14) ? 8'h00 : m[a];
	endfunction
	task automatic check(string n, logic [7:0] s, logic [7:0] e);
		samples_checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic mdl_wr(int a, logic [7:0] d);
		logic [7:0] k;
		k = (a < 7) ? MASK_TIME[a] : (a < 11) ? MASK_ALM[a - 7] : (a == 11) ? MASK_CONTROL :
			(a == 13) ? MASK_WDOG : 8'h00;
		if (a >= 7 && a <= 10)
			flag = 0;
		if (m[11][CTL_WLOCK])
			k = (a == 11) ? 8'h40 : 8'h00;
		if (k != 8'h00)
			m[a] = (m[a] & ~k) | (d & k);
	endtask
	task automatic wr(int a, int n);
		u_host.frame(8'h80 | 8'(a), n);
		for (int k = 0; k < n; k++)
		begin
			mdl_wr(a, u_host.dat[k]);
			a = nx(a);
		end
	endtask
	task automatic wr1(int a, logic [7:0] d);
		u_host.dat[0] = d;
		wr(a, 1);
	endtask
	task automatic rd(int a, int n);
		u_host.frame(8'(a), n);
		for (int k = 0; k < n; k++)
		begin
			check("reg", u_host.dat[k], exp_rd(a));
			if (a >= 7 && a <= 10)
				flag = 0;
			a = nx(a);
		end
	endtask
	task automatic tick();
		repeat (4)
		begin
			xtal = 1;
			repeat (3) @(negedge clk);
			xtal = 0;
			repeat (3) @(negedge clk);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		for (int j = 0; j < 15; j++)
			m[j] = (j < 7) ? RST_TIME[j] : (j == 11) ? RST_CONTROL : (j == 13) ? RST_WDOG : 8'h00;
		repeat (4) @(negedge clk);
		rst_b = 1;
		repeat (4) @(negedge clk);
		check("wdog", {6'h00, wdp}, 8'h03);
		check("sel", {5'h00, sel}, 8'h00);
		rd(11, 4);
		$display("test reset done");
		for (int it = 0; it < 3; it++)
		begin
			adc = rnd();
			{conv, hi, lo} = 3'(rnd());
			repeat (8) @(negedge clk);
			bat = hi ? 1'b0 : (lo ? 1'b1 : bat);
			for (int j = 0; j < 14; j++)
				u_host.dat[j] = rnd();
			wr(0, 14);
			rd(0, 16);
			check("wdp", {6'h00, wdp}, m[13]);
		end
		$display("test burst done");
		wr1(11, 8'hf1);
		wr1(0, 8'h33);
		wr1(11, 8'h00);
		rd(0, 1);
		rd(11, 1);
		wr1(11, 8'h00);
		wr1(16, 8'h5a);
		rd(15, 2);
		rd(127, 2);
		$display("test lock done");
		for (int s = 0; s < 4; s++)
		begin
			wr1(11, 8'h80 | 8'(s << 4));
			check("sel", {5'h00, sel}, (s == 0) ? 8'h00 : 8'(1 << (s - 1)));
		end
		// stop bit is set here, so on battery the oscillator must go off
		pwr = 0;
		repeat (6) @(negedge clk);
		check("osc", {7'h00, osc}, 8'h00);
		pwr = 1;
		repeat (6) @(negedge clk);
		check("osc", {7'h00, osc}, 8'h01);
		$display("test select done");
		// ticks are only made here, so register reads above never race the count
		for (int r = 0; r < 8; r++)
		begin
			for (int j = 0; j < 12; j++)
				u_host.dat[j] = row[r][8 * (19 - j) +: 8];
			wr(0, 12);
			tick();
			repeat (6) @(negedge clk);
			for (int j = 0; j < 7; j++)
				m[j] = row[r][8 * (7 - j) +: 8];
			flag = row[r][0];
			check("irq", {7'h00, irq}, {7'h00, flag & m[11][CTL_AIE]});
			rd(12, 1);
			check("irq", {7'h00, irq}, {7'h00, flag & m[11][CTL_AIE]});
			rd(7, 1);
			check("irq", {7'h00, irq}, 8'h00);
			rd(0, 7);
		end
		$display("test alarm done");
		report_and_stop();
	end
	initial
	begin
		repeat (100000) @(negedge clk);
		fail_count++;
		report_and_stop();
	end
endmodule // rtcac_top_bench
`default_nettype wire
